// file: headset_detect_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
module headset_detect_config_regs (
    input  wire logic                               i_ref_clk,
    input  wire logic                               i_nrst,
    input  wire logic [7:0]                         i_reg_addr,
    input  wire logic                               i_reg_wr,
    input  wire logic [7:0]                         i_reg_wdata,
    input  wire logic                               i_reg_rd,
    output logic      [7:0]                         o_reg_rdata,
    input  wire logic                               i_external_resistor_type_bit,
    output logic                                    o_headset_detect_enable,
    output logic                                    o_headphone_coupling_select,
    output logic                                    o_detect_current_double,
    output logic                                    o_hook_threshold_select,
    output logic      [1:0]                         o_hook_pressed_insert_min_impedance,
    output logic      [6:0]                         o_config_third,
    output logic      [jack_detect_pkg::OHM_W-1:0]  o_hook_max_ohms,
    output logic      [jack_detect_pkg::OHM_W-1:0]  o_mic_min_ohms,
    output logic      [jack_detect_pkg::OHM_W-1:0]  o_insert_hook_min_ohms,
    output logic                                    o_insert_support_valid
);
    import jack_detect_pkg::*;

    logic [7:0]       config_second;
    logic [7:0]       config_third;
    logic [OHM_W-1:0] next_hook_max;
    logic [OHM_W-1:0] next_mic_min;
    logic [OHM_W-1:0] next_insert_min;
    logic             next_insert_valid;
    logic             wr_second;
    logic             wr_third;

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    assign wr_second = i_reg_wr && (i_reg_addr == ADDR_CONFIG_SECOND);
    assign wr_third  = i_reg_wr && (i_reg_addr == ADDR_CONFIG_THIRD);

    // reserved bits 7 and 0 never store, so a stray write cannot leak into readback
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            config_second <= RESET_CONFIG_SECOND;
        end else if (wr_second) begin
            config_second <= {1'b0, i_reg_wdata[6:1], 1'b0};
        end
    end

    // third register only holds its fields for the debounce logic elsewhere
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            config_third <= RESET_CONFIG_THIRD;
        end else if (wr_third) begin
            config_third <= i_reg_wdata & MASK_THIRD;
        end
    end

    // ----------------------------------------------------------------
    // readback
    // ----------------------------------------------------------------
    // data one cycle after the read strobe; reads touch no state
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_reg_rdata <= READ_UNMAPPED;
        end else if (i_reg_rd) begin
            case (i_reg_addr)
                ADDR_CONFIG_SECOND: o_reg_rdata <= config_second;
                ADDR_CONFIG_THIRD:  o_reg_rdata <= config_third;
                default:            o_reg_rdata <= READ_UNMAPPED;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // controls to the analog detector
    // ----------------------------------------------------------------
    assign o_headset_detect_enable             = config_second[BIT_ENABLE];
    assign o_headphone_coupling_select         = config_second[BIT_COUPLING];
    assign o_detect_current_double             = config_second[BIT_CURRENT];
    assign o_hook_threshold_select             = config_second[BIT_THRESHOLD];
    assign o_hook_pressed_insert_min_impedance = config_second[BIT_INSERT_HI:BIT_INSERT_LO];
    assign o_config_third                      = config_third[6:0];

    // threshold trade-off depends on coupling: DC lowers the hook limit at setting 0, raises the mic minimum at 1
    always_comb begin
        next_hook_max = OHM_HOOK_AC_LOW;
        next_mic_min  = OHM_MIC_AC_LOW;
        if (config_second[BIT_THRESHOLD]) begin
            next_hook_max = OHM_HOOK_HIGH;
            next_mic_min  = config_second[BIT_COUPLING] ? OHM_MIC_DC_HIGH : OHM_MIC_AC_HIGH;
        end else begin
            next_hook_max = config_second[BIT_COUPLING] ? OHM_HOOK_DC_LOW : OHM_HOOK_AC_LOW;
            next_mic_min  = OHM_MIC_AC_LOW;
        end
    end

    // insertion support is ignored with the other resistor type or the reserved code
    always_comb begin
        next_insert_valid = !i_external_resistor_type_bit;
        case (insert_code_t'(config_second[BIT_INSERT_HI:BIT_INSERT_LO]))
            INSERT_MIN_150: next_insert_min = OHM_INSERT_150;
            INSERT_MIN_100: next_insert_min = OHM_INSERT_100;
            INSERT_MIN_50:  next_insert_min = OHM_INSERT_50;
            default: begin
                next_insert_min   = OHM_NONE;
                next_insert_valid = 1'b0;
            end
        endcase
        if (i_external_resistor_type_bit) begin
            next_insert_min = OHM_NONE;
        end
    end

    // limits registered so the analog side sees glitch-free values, one cycle late
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_hook_max_ohms        <= OHM_HOOK_AC_LOW;
            o_mic_min_ohms         <= OHM_MIC_AC_LOW;
            o_insert_hook_min_ohms <= OHM_NONE;
            o_insert_support_valid <= 1'b0;
        end else begin
            o_hook_max_ohms        <= next_hook_max;
            o_mic_min_ohms         <= next_mic_min;
            o_insert_hook_min_ohms <= next_insert_min;
            o_insert_support_valid <= next_insert_valid;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    // write path: each field follows the written byte one edge later
    AST_ENABLE_WRITE: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        wr_second |=> o_headset_detect_enable == $past(i_reg_wdata[1]))
        else $error("enable bit did not follow write");
    AST_COUPLING_WRITE: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        wr_second |=> o_headphone_coupling_select == $past(i_reg_wdata[3]))
        else $error("coupling bit did not follow write");
    AST_CURRENT_WRITE: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        wr_second |=> o_detect_current_double == $past(i_reg_wdata[2]))
        else $error("current bit did not follow write");

    // limits trail the fields by one more edge, hence the $past of the threshold
    AST_AC_LIMITS: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        !o_headphone_coupling_select |=>
            (o_mic_min_ohms == ($past(o_hook_threshold_select)
                ? OHM_MIC_AC_HIGH : OHM_MIC_AC_LOW))
            && (o_hook_max_ohms == ($past(o_hook_threshold_select)
                ? OHM_HOOK_HIGH : OHM_HOOK_AC_LOW)))
        else $error("AC coupled limits wrong");
    AST_DC_LIMITS: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        o_headphone_coupling_select |=>
            (o_mic_min_ohms == ($past(o_hook_threshold_select)
                ? OHM_MIC_DC_HIGH : OHM_MIC_AC_LOW))
            && (o_hook_max_ohms == ($past(o_hook_threshold_select)
                ? OHM_HOOK_HIGH : OHM_HOOK_DC_LOW)))
        else $error("DC coupled limits wrong");

    // insertion support decode, gated by the resistor type bit
    AST_INSERT_MIN: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (!i_external_resistor_type_bit && o_hook_pressed_insert_min_impedance == 2'h1)
        |=> o_insert_support_valid && o_insert_hook_min_ohms == OHM_INSERT_100)
        else $error("insertion minimum wrong for code 1");
    AST_INSERT_IGNORED: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (i_external_resistor_type_bit || o_hook_pressed_insert_min_impedance == 2'b11)
        |=> !o_insert_support_valid)
        else $error("insertion support not ignored");

    // readback: a read without a write in the same cycle shows the stored bits
    AST_RESERVED_READ: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (i_reg_rd && i_reg_addr == ADDR_CONFIG_SECOND)
        |=> o_reg_rdata[0] == 1'b0 && o_reg_rdata[7] == 1'b0)
        else $error("reserved bits of second register read nonzero");
    AST_THIRD_READ: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (i_reg_rd && !i_reg_wr && i_reg_addr == ADDR_CONFIG_THIRD)
        |=> o_reg_rdata == {1'b0, o_config_third})
        else $error("third register readback wrong");
    AST_SECOND_READ: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (i_reg_rd && !i_reg_wr && i_reg_addr == ADDR_CONFIG_SECOND) |=> o_reg_rdata == {1'b0,
            o_hook_threshold_select, o_hook_pressed_insert_min_impedance,
            o_headphone_coupling_select, o_detect_current_double,
            o_headset_detect_enable, 1'b0})
        else $error("second register readback wrong");
    AST_READ_NO_EFFECT: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (i_reg_rd && !i_reg_wr) |=> $stable(config_second) && $stable(config_third))
        else $error("read disturbed configuration");
    AST_UNMAPPED_READ: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (i_reg_rd && i_reg_addr != ADDR_CONFIG_SECOND && i_reg_addr != ADDR_CONFIG_THIRD)
        |=> o_reg_rdata == READ_UNMAPPED)
        else $error("unmapped read returned data");

    // remaining fields, and the hold between writes
    AST_THRESHOLD_WRITE: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        wr_second |=> o_hook_threshold_select == $past(i_reg_wdata[BIT_THRESHOLD]))
        else $error("threshold bit did not follow write");
    AST_INSERT_FIELD_WRITE: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        wr_second |=> o_hook_pressed_insert_min_impedance
            == $past(i_reg_wdata[BIT_INSERT_HI:BIT_INSERT_LO]))
        else $error("insertion field did not follow write");
    AST_THIRD_WRITE: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        wr_third |=> o_config_third == $past(i_reg_wdata[6:0]))
        else $error("third register did not follow write");
    // writes to any other address must leave the second register's controls alone
    AST_FIELDS_HOLD: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        !wr_second |=> $stable(config_second))
        else $error("second register changed without a write");
    AST_INSERT_EDGE_CODES: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (!i_external_resistor_type_bit && o_hook_pressed_insert_min_impedance != 2'h1
            && o_hook_pressed_insert_min_impedance != 2'h3)
        |=> o_insert_support_valid && o_insert_hook_min_ohms ==
            ($past(o_hook_pressed_insert_min_impedance[1]) ? OHM_INSERT_50 : OHM_INSERT_150))
        else $error("insertion minimum wrong for code 0 or 2");

    // ----------------------------------------------------------------
    // coverage
    // ----------------------------------------------------------------
    // main scenarios: enable, both DC threshold corners, insertion, third register
    COV_ENABLE_ON: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
        wr_second && i_reg_wdata[1] ##1 o_headset_detect_enable);
    COV_DC_HIGH: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
        o_mic_min_ohms == OHM_MIC_DC_HIGH);
    COV_DC_LOW: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
        o_hook_max_ohms == OHM_HOOK_DC_LOW);
    COV_INSERT_50: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
        o_insert_support_valid && o_insert_hook_min_ohms == OHM_INSERT_50);
    COV_THIRD_RW: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
        wr_third ##1 (i_reg_rd && i_reg_addr == ADDR_CONFIG_THIRD));

endmodule
`default_nettype wire

// file: jack_detect_pkg.sv
// How it works
// - detection-enable bit 1 turns headset detection off at 0, on at 1; resets 0
// - coupling bit 3 selects AC coupling at 0, DC coupling at 1; resets 0
// - current bit 2 doubles headphone-detection current only while 1; resets 0
// - threshold bit 6, AC: 0 gives mic 800/hook 320, 1 gives hook 680/mic 1350
// - under DC coupling hook limit becomes 150 (setting 0), mic minimum 1750 (setting 1)
// - bits 5-4 pick insertion hook minimum 150/100/50, code 3 reserved, needs type bit 0
// - bit 0 of second register is reserved, reads 0; software writes only 0 there
// - third register lives at 0x1B and resets to 0x00
// - second register lives at 0x1A and resets to 0x00
`default_nettype none
package jack_detect_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CONFIG_SECOND  = 8'h1A;
    localparam logic [7:0] ADDR_CONFIG_THIRD   = 8'h1B;
    localparam logic [7:0] RESET_CONFIG_SECOND = 8'h00;
    localparam logic [7:0] RESET_CONFIG_THIRD  = 8'h00;
    localparam logic [7:0] READ_UNMAPPED       = 8'h00;

    // ----------------------------------------------------------------
    // second register field positions
    // ----------------------------------------------------------------
    localparam int BIT_ENABLE      = 1;
    localparam int BIT_CURRENT     = 2;
    localparam int BIT_COUPLING    = 3;
    localparam int BIT_INSERT_LO   = 4;
    localparam int BIT_INSERT_HI   = 5;
    localparam int BIT_THRESHOLD   = 6;
    // third register keeps bits 6..0 writable, bit 7 reserved
    localparam logic [7:0] MASK_THIRD = 8'h7F;

    // ----------------------------------------------------------------
    // impedance limits in ohms
    // ----------------------------------------------------------------
    localparam int OHM_W = 11;
    localparam logic [OHM_W-1:0] OHM_MIC_AC_LOW   = 11'h320; // 800
    localparam logic [OHM_W-1:0] OHM_HOOK_AC_LOW  = 11'h140; // 320
    localparam logic [OHM_W-1:0] OHM_HOOK_HIGH    = 11'h2A8; // 680
    localparam logic [OHM_W-1:0] OHM_MIC_AC_HIGH  = 11'h546; // 1350
    localparam logic [OHM_W-1:0] OHM_HOOK_DC_LOW  = 11'h096; // 150
    localparam logic [OHM_W-1:0] OHM_MIC_DC_HIGH  = 11'h6D6; // 1750
    localparam logic [OHM_W-1:0] OHM_INSERT_150   = 11'h096; // 150
    localparam logic [OHM_W-1:0] OHM_INSERT_100   = 11'h064; // 100
    localparam logic [OHM_W-1:0] OHM_INSERT_50    = 11'h032; // 50
    localparam logic [OHM_W-1:0] OHM_NONE         = 11'h000;

    typedef enum logic [1:0] {
        INSERT_MIN_150 = 2'b00,
        INSERT_MIN_100 = 2'b01,
        INSERT_MIN_50  = 2'b10,
        INSERT_RSVD    = 2'b11
    } insert_code_t;

endpackage
`default_nettype wire

// file: test_headset_detect_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// shared compare: counts every check, reports a mismatch at once
// ------------------------------------------------------------
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module test_headset_detect_config_regs;
    import jack_detect_pkg::*;
    logic              i_ref_clk;
    logic              i_nrst;
    logic [7:0]        i_reg_addr;
    logic              i_reg_wr;
    logic [7:0]        i_reg_wdata;
    logic              i_reg_rd;
    logic [7:0]        o_reg_rdata;
    logic              i_external_resistor_type_bit;
    logic              o_headset_detect_enable;
    logic              o_headphone_coupling_select;
    logic              o_detect_current_double;
    logic              o_hook_threshold_select;
    logic [1:0]        o_hook_pressed_insert_min_impedance;
    logic [6:0]        o_config_third;
    logic [OHM_W-1:0]  o_hook_max_ohms;
    logic [OHM_W-1:0]  o_mic_min_ohms;
    logic [OHM_W-1:0]  o_insert_hook_min_ohms;
    logic              o_insert_support_valid;
    int                n_mismatch = 0;
    int                compares = 0;
    // limits per {threshold, coupling} and per insertion code
    logic [OHM_W-1:0]  exp_hook [4] = '{OHM_HOOK_AC_LOW, OHM_HOOK_DC_LOW, OHM_HOOK_HIGH,
                                        OHM_HOOK_HIGH};
    logic [OHM_W-1:0]  exp_mic  [4] = '{OHM_MIC_AC_LOW, OHM_MIC_AC_LOW, OHM_MIC_AC_HIGH,
                                        OHM_MIC_DC_HIGH};
    logic [OHM_W-1:0]  exp_ins  [4] = '{OHM_INSERT_150, OHM_INSERT_100, OHM_INSERT_50,
                                        OHM_NONE};

    headset_detect_config_regs dut_u (
        .i_ref_clk                           (i_ref_clk),
        .i_nrst                              (i_nrst),
        .i_reg_addr                          (i_reg_addr),
        .i_reg_wr                            (i_reg_wr),
        .i_reg_wdata                         (i_reg_wdata),
        .i_reg_rd                            (i_reg_rd),
        .o_reg_rdata                         (o_reg_rdata),
        .i_external_resistor_type_bit        (i_external_resistor_type_bit),
        .o_headset_detect_enable             (o_headset_detect_enable),
        .o_headphone_coupling_select         (o_headphone_coupling_select),
        .o_detect_current_double             (o_detect_current_double),
        .o_hook_threshold_select             (o_hook_threshold_select),
        .o_hook_pressed_insert_min_impedance (o_hook_pressed_insert_min_impedance),
        .o_config_third                      (o_config_third),
        .o_hook_max_ohms                     (o_hook_max_ohms),
        .o_mic_min_ohms                      (o_mic_min_ohms),
        .o_insert_hook_min_ohms              (o_insert_hook_min_ohms),
        .o_insert_support_valid              (o_insert_support_valid)
    );

    // ------------------------------------------------------------
    // clock, 20 ns period
    // ------------------------------------------------------------
    initial begin
        i_ref_clk = 1'b0;
        forever #10 i_ref_clk = ~i_ref_clk;
    end

    // ------------------------------------------------------------
    // access tasks: drive 1 ns after the edge so sampling never races
    // ------------------------------------------------------------
    task automatic tick();
        @(posedge i_ref_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        i_reg_addr = addr;
        i_reg_wdata = data;
        i_reg_wr = 1'b1;
        tick();
        i_reg_wr = 1'b0;
        // idle edge, so the next call never raises the strobe in the same step
        tick();
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        i_reg_addr = addr;
        i_reg_rd = 1'b1;
        tick();
        i_reg_rd = 1'b0;
        // read data stands until the next read, so the idle edge costs nothing
        tick();
        `CHK(o_reg_rdata, exp)
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // watchdog: the sequence needs well under 200 cycles
    // ------------------------------------------------------------
    initial begin
        #20000;
        n_mismatch++;
        finish_test();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        i_nrst = 1'b0;
        i_reg_addr = 8'h00;
        i_reg_wr = 1'b0;
        i_reg_wdata = 8'h00;
        i_reg_rd = 1'b0;
        i_external_resistor_type_bit = 1'b0;
        repeat (5) @(posedge i_ref_clk);
        #1;
        i_nrst = 1'b1;
        rd_chk(ADDR_CONFIG_SECOND, 8'h00);
        rd_chk(ADDR_CONFIG_THIRD, 8'h00);
        `CHK(o_headset_detect_enable, 1'b0)
        // enable, DC coupling, high threshold in one write
        wr(ADDR_CONFIG_SECOND, 8'h4A);
        `CHK({o_headset_detect_enable, o_headphone_coupling_select}, 2'b11)
        `CHK(o_detect_current_double, 1'b0)
        tick();
        `CHK(o_mic_min_ohms, 11'd1750)
        rd_chk(ADDR_CONFIG_SECOND, 8'h4A);
        `CHK(o_hook_threshold_select, 1'b1)
        // reserved bit 7 is not stored; bit 0 only ever gets its reset value
        wr(ADDR_CONFIG_SECOND, 8'hFE);
        `CHK(o_detect_current_double, 1'b1)
        rd_chk(ADDR_CONFIG_SECOND, 8'h7E);
        // unmapped address: write dropped, read gives zero
        wr(8'h1C, 8'hFF);
        rd_chk(8'h1C, 8'h00);
        rd_chk(ADDR_CONFIG_SECOND, 8'h7E);
        wr(ADDR_CONFIG_THIRD, 8'hFF);
        `CHK(o_config_third, 7'h7F)
        rd_chk(ADDR_CONFIG_THIRD, 8'h7F);
        // every coupling and threshold combination
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_CONFIG_SECOND, {1'b0, k[1], 2'b00, k[0], 3'b000});
            tick();
            `CHK(o_hook_max_ohms, exp_hook[k])
            `CHK(o_mic_min_ohms, exp_mic[k])
        end
        // every insertion code, with the resistor type bit both ways
        for (int t = 0; t < 2; t++) begin
            for (int c = 0; c < 4; c++) begin
                i_external_resistor_type_bit = t[0];
                wr(ADDR_CONFIG_SECOND, {2'b00, c[1:0], 4'h0});
                `CHK(o_hook_pressed_insert_min_impedance, c[1:0])
                tick();
                `CHK(o_insert_hook_min_ohms, (t == 0) ? exp_ins[c] : OHM_NONE)
                `CHK(o_insert_support_valid, (t == 0 && c != 3))
            end
        end
        // mid-run reset brings registers and limits back to their reset state
        i_nrst = 1'b0;
        tick();
        `CHK(o_hook_max_ohms, OHM_HOOK_AC_LOW)
        `CHK(o_mic_min_ohms, OHM_MIC_AC_LOW)
        `CHK(o_insert_support_valid, 1'b0)
        `CHK(o_config_third, 7'h00)
        i_nrst = 1'b1;
        rd_chk(ADDR_CONFIG_SECOND, RESET_CONFIG_SECOND);
        rd_chk(ADDR_CONFIG_THIRD, RESET_CONFIG_THIRD);
        finish_test();
    end
endmodule
`default_nettype wire
